// File: src/dac_alarm_status_control.sv
// Purpose: control and write-to-clear alarm registers of the output block
// Assumes: plain register port, read data one cycle after read strobe
// Notes: alarms are sticky; writing a one clears a bit
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`include "alarm_regs_consts.svh"
// Operation
// - 4-bit full-scale step in control bits 15:12, reset 1111.
// - writing control bit 0 high forces internal transmit enable.
// - transmit enabled if register bit or pin high.
// - fail map bit set for each failing data bit position.
// - each fail bit covers same position on both input buses.
// - fail map not reset; host write of ones clears it.
// - zero-check alarm bit 15 when write pointer is all zeros.
// - pointer proximity field 13:11: normal, two, one apart, collision.
// - alarm bit 10 on conversion clock loss; host clears it.
// - alarm bit 9 on data clock loss; host clears it.
// - muted bit 8 on clock loss or collision; outputs become 0x8000.
// - mismatch alarm bit 7 when input differs from expected pattern.
// - in checker mode only the mismatch alarm is meaningful.
// - per-fault enables shut outputs off when alarms are unmasked.
// - 16-bit alarm mask, one masks, resets to all ones.
module dac_alarm_status_control #(
    parameter int DW = 16,
    parameter int NCH = 4
) (
    input wire logic mclk_i,                  // system clock 25 MHz
    input wire logic rstn_i,                  // sync reset, active low
    input wire logic ce_i,                    // clock enable
    input wire logic [7:0] addr_i,            // register index
    input wire logic [DW-1:0] wdata_i,        // write data
    input wire logic wr_i,                    // write strobe
    input wire logic rd_i,                    // read strobe
    output logic [DW-1:0] rdata_o,            // read data, cycle after rd
    input wire logic transmit_enable_pin_i,   // async pin
    input wire logic conv_clk_i,              // conversion clock, watched
    input wire logic data_clk_i,              // data clock, watched
    input wire logic [7:0] wr_ptr_i,          // fifo write pointer
    input wire logic [2:0] fifo_near_i,       // 001 two, 01x one, 1xx hit
    input wire logic [DW-1:0] first_input_bus_i,  // input data bus A
    input wire logic [DW-1:0] second_input_bus_i, // input data bus B
    input wire logic [NCH*DW-1:0] samples_i,  // samples toward converters
    output logic [NCH*DW-1:0] samples_o,      // samples, muted if needed
    output logic [3:0] full_scale_o,          // output current step
    output logic tx_enable_o,                 // internal transmit enable
    output logic shutdown_o,                  // outputs shut off
    output logic irq_o                        // level interrupt
);
    typedef struct packed {
        logic [DW-1:0] scale_tx;
        logic [DW-1:0] fail_map;
        logic [DW-1:0] alarm;
        logic [DW-1:0] shut_ena;
        logic [DW-1:0] alarm_mask;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic pat_en;
        logic [DW-1:0] pat_exp;
        logic [DW-1:0] rdata;
        logic pin_s1;
        logic pin_s2;
        logic [NCH*DW-1:0] samples;
    } bank_t;
    bank_t q, d;

    logic conv_lost, data_lost;
    logic [DW-1:0] fail_now;
    logic [DW-1:0] alarm_set;
    logic muted, shut;

    clock_loss_watch u_conv (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .wclk_i(conv_clk_i),
        .lost_o(conv_lost)
    );
    clock_loss_watch u_data (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .wclk_i(data_clk_i),
        .lost_o(data_lost)
    );
    pattern_compare #(.W(DW)) u_pat (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .en_i(q.pat_en),
        .bus_a_i(first_input_bus_i),
        .bus_b_i(second_input_bus_i),
        .expect_i(q.pat_exp),
        .fail_o(fail_now)
    );

    // events that raise alarm bits this cycle
    always_comb begin
        alarm_set = '0;
        alarm_set[`BIT_ZEROCHK] = (wr_ptr_i == 8'h00);
        if (fifo_near_i[2]) begin
            alarm_set[`BIT_FIFO_HI] = 1'b1;
        end else if (fifo_near_i[1]) begin
            alarm_set[`BIT_FIFO_HI-1] = 1'b1;
        end else if (fifo_near_i[0]) begin
            alarm_set[`BIT_FIFO_LO] = 1'b1;
        end
        alarm_set[`BIT_CONVCLK] = conv_lost;
        alarm_set[`BIT_DATACLK] = data_lost;
        alarm_set[`BIT_PATTERN] = |fail_now;
    end

    // mute follows the sticky alarm bits themselves
    assign muted = q.alarm[`BIT_CONVCLK] | q.alarm[`BIT_DATACLK] |
        q.alarm[`BIT_FIFO_HI];
    // a masked alarm, or a masked mute bit, cannot shut the outputs off
    assign shut = ~q.alarm_mask[`BIT_MUTED] & (
        (q.shut_ena[`BIT_CONV_ENA] & q.alarm[`BIT_CONVCLK] &
         ~q.alarm_mask[`BIT_CONVCLK]) |
        (q.shut_ena[`BIT_DATA_ENA] & q.alarm[`BIT_DATACLK] &
         ~q.alarm_mask[`BIT_DATACLK]) |
        (q.shut_ena[`BIT_COLL_ENA] & q.alarm[`BIT_FIFO_HI] &
         ~q.alarm_mask[`BIT_FIFO_HI]));

    always_comb begin
        d = q;
        d.pin_s1 = transmit_enable_pin_i;
        d.pin_s2 = q.pin_s1;
        d.rdata = '0;
        // set wins over a clear arriving in the same cycle
        d.fail_map = (q.fail_map & ~((wr_i && addr_i == `OFS_FAIL_MAP) ?
            wdata_i : '0)) | fail_now;
        d.alarm = (q.alarm & ~((wr_i && addr_i == `OFS_ALARM) ?
            wdata_i : '0)) | alarm_set;
        if (muted || alarm_set[`BIT_CONVCLK] || alarm_set[`BIT_DATACLK] ||
            alarm_set[`BIT_FIFO_HI]) begin
            d.alarm[`BIT_MUTED] = 1'b1;
        end
        d.irq_stat = q.irq_stat;
        if (wr_i && addr_i == `OFS_IRQ_STAT) begin
            d.irq_stat = q.irq_stat & ~wdata_i[2:0];
        end
        d.irq_stat = d.irq_stat | {|fail_now,
            conv_lost | data_lost, alarm_set[`BIT_FIFO_HI]};
        if (wr_i) begin
            case (addr_i)
                `OFS_SCALE_TX: d.scale_tx = wdata_i;
                `OFS_SHUT_ENA: d.shut_ena = wdata_i;
                `OFS_ALARM_MASK: d.alarm_mask = wdata_i;
                `OFS_IRQ_MASK: d.irq_mask = wdata_i[2:0];
                `OFS_PAT_CTRL: d.pat_en = wdata_i[0];
                `OFS_PAT_EXP: d.pat_exp = wdata_i;
                default: begin
                end
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                `OFS_SCALE_TX: d.rdata = q.scale_tx;
                `OFS_FAIL_MAP: d.rdata = q.fail_map;
                `OFS_ALARM: d.rdata = q.alarm;
                `OFS_SHUT_ENA: d.rdata = q.shut_ena;
                `OFS_ALARM_MASK: d.rdata = q.alarm_mask;
                `OFS_IRQ_STAT: d.rdata = {13'h0000, q.irq_stat};
                `OFS_IRQ_MASK: d.rdata = {13'h0000, q.irq_mask};
                `OFS_PAT_CTRL: d.rdata = {15'h0000, q.pat_en};
                `OFS_PAT_EXP: d.rdata = q.pat_exp;
                default: d.rdata = '0;
            endcase
        end
        for (int c = 0; c < NCH; c++) begin
            d.samples[c*DW +: DW] = (muted || shut) ? `MUTE_VALUE :
                samples_i[c*DW +: DW];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            q.scale_tx <= `RST_SCALE_TX;
            q.alarm <= '0;
            q.shut_ena <= `RST_SHUT_ENA;
            q.alarm_mask <= `RST_ALARM_MASK;
            q.irq_stat <= 3'h0;
            q.irq_mask <= 3'h7;
            q.pat_en <= 1'b0;
            q.pat_exp <= '0;
            q.rdata <= '0;
            q.pin_s1 <= 1'b0;
            q.pin_s2 <= 1'b0;
            q.samples <= '0;
            q.fail_map <= d.fail_map;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign full_scale_o = q.scale_tx[15:12];
    assign tx_enable_o = q.scale_tx[0] | q.pin_s2;
    assign shutdown_o = shut;
    assign samples_o = q.samples;
    assign irq_o = |(q.irq_stat & ~q.irq_mask);

    // in checker mode software reads only the mismatch bit

    // pin path is checked two edges back, so only runs of ce and reset count
    AST_TX_OR: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        ($past(rstn_i) && $past(rstn_i, 2) && $past(ce_i) && $past(ce_i, 2))
        |-> tx_enable_o ==
        (q.scale_tx[0] | $past(transmit_enable_pin_i, 2)))
        else $error("tx enable not the or of bit and pin");
    AST_SCALE_RST: assert property (@(posedge mclk_i)
        $rose(rstn_i) |-> full_scale_o == 4'hF)
        else $error("full scale step not all ones after reset");
    AST_TX_WRITE: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && wr_i && addr_i == `OFS_SCALE_TX && wdata_i[0])
        |=> tx_enable_o)
        else $error("write of tx bit did not enable");
    AST_ZERO_PTR: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && wr_ptr_i == 8'h00) |=> q.alarm[`BIT_ZEROCHK])
        else $error("zero pointer alarm missing");
    AST_STICKY: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (q.alarm[`BIT_DATACLK] && !(wr_i && addr_i == `OFS_ALARM))
        |=> q.alarm[`BIT_DATACLK])
        else $error("alarm bit dropped without a clear");
    AST_CLEAR: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && wr_i && addr_i == `OFS_ALARM && wdata_i[`BIT_ZEROCHK] &&
        wr_ptr_i != 8'h00) |=> !q.alarm[`BIT_ZEROCHK])
        else $error("alarm bit not cleared by a one");
    AST_MUTE_DATA: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && muted) |=> samples_o[DW-1:0] == `MUTE_VALUE)
        else $error("muted output not mid scale");
    // every lane is checked, not only the first
    for (genvar c = 0; c < NCH; c++) begin : g_mute_lane
        AST_MUTE_LANE: assert property (@(posedge mclk_i)
            disable iff (!rstn_i)
            (ce_i && muted) |=> samples_o[c*DW +: DW] == `MUTE_VALUE)
            else $error("muted lane not mid scale");
    end
    AST_MUTE_BIT: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && q.alarm[`BIT_CONVCLK]) |=> q.alarm[`BIT_MUTED])
        else $error("muted alarm not raised");
    AST_COLLIDE: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && fifo_near_i[2]) |=> q.alarm[`BIT_FIFO_HI])
        else $error("collision alarm missing");
    AST_ONE_AWAY: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && fifo_near_i[2:1] == 2'h1) |=> q.alarm[`BIT_FIFO_HI-1])
        else $error("one apart alarm missing");
    AST_TWO_AWAY: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && fifo_near_i == 3'h1) |=> q.alarm[`BIT_FIFO_LO])
        else $error("two apart alarm missing");
    AST_CONV_LOST: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && conv_lost) |=> q.alarm[`BIT_CONVCLK])
        else $error("conversion clock alarm missing");
    AST_DATA_LOST: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && data_lost) |=> q.alarm[`BIT_DATACLK])
        else $error("data clock alarm missing");
    AST_PAT_ALARM: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && |fail_now) |=> q.alarm[`BIT_PATTERN])
        else $error("mismatch alarm missing");
    AST_PAT_GATED: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && $past(ce_i) && !q.pat_en && !$past(q.pat_en) &&
        !q.alarm[`BIT_PATTERN]) |=> !q.alarm[`BIT_PATTERN])
        else $error("mismatch alarm raised outside checker mode");
    AST_FAILMAP: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && fail_now[0]) |=> q.fail_map[0])
        else $error("fail map bit not set");
    AST_FAIL_CLR: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && wr_i && addr_i == `OFS_FAIL_MAP && wdata_i[0] &&
        !fail_now[0]) |=> !q.fail_map[0])
        else $error("fail map bit not cleared by a one");
    AST_MASK_RST: assert property (@(posedge mclk_i)
        $rose(rstn_i) |-> q.alarm_mask == `RST_ALARM_MASK)
        else $error("mask not all ones after reset");
    AST_SHUT: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (q.alarm_mask[`BIT_CONVCLK]) |-> !(shut && !q.alarm[`BIT_DATACLK]
        && !q.alarm[`BIT_FIFO_HI]))
        else $error("masked alarm shut the outputs");
    AST_SHUT_MUTE: assert property (@(posedge mclk_i)
        disable iff (!rstn_i)
        (ce_i && shutdown_o) |=> samples_o == {NCH{`MUTE_VALUE}})
        else $error("shut outputs not mid scale");
    COV_MUTE: cover property (@(posedge mclk_i) $rose(muted));
    COV_IRQ: cover property (@(posedge mclk_i) $rose(irq_o));
    COV_PAT: cover property (@(posedge mclk_i) q.alarm[`BIT_PATTERN]);
    COV_SHUT: cover property (@(posedge mclk_i) $rose(shutdown_o));
    COV_LOST: cover property (@(posedge mclk_i) conv_lost || data_lost);
endmodule

// File: pkg/alarm_regs_consts.svh
// Purpose: offsets, field positions, reset values for the alarm register bank
// Assumes: 8-bit register index, 16-bit data
// Notes: offsets are register indices on the plain register port
`ifndef ALARM_REGS_CONSTS_SVH
`define ALARM_REGS_CONSTS_SVH
`define OFS_SCALE_TX 8'h03
`define OFS_FAIL_MAP 8'h04
`define OFS_ALARM 8'h05
`define OFS_SHUT_ENA 8'h02
`define OFS_ALARM_MASK 8'h07
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h09
`define OFS_PAT_CTRL 8'h0A
`define OFS_PAT_EXP 8'h0B
`define RST_SCALE_TX 16'hF000
`define RST_SHUT_ENA 16'h7000
`define RST_ALARM_MASK 16'hFFFF
`define RST_IRQ_MASK 16'hFFFF
`define BIT_ZEROCHK 15
`define BIT_FIFO_HI 13
`define BIT_FIFO_LO 11
`define BIT_CONVCLK 10
`define BIT_DATACLK 9
`define BIT_MUTED 8
`define BIT_PATTERN 7
`define BIT_CONV_ENA 14
`define BIT_DATA_ENA 13
`define BIT_COLL_ENA 12
`define MUTE_VALUE 16'h8000
`define CLK_LOSS_CYCLES 16
`endif

// File: pkg/alarm_regs_pkg.sv
// Purpose: types shared by the alarm register bank
// Assumes: nothing beyond the consts header
// Notes: states of the clock-loss watcher
package alarm_regs_pkg;
    typedef enum logic [1:0] {
        WATCH_IDLE = 2'b01,
        WATCH_LOST = 2'b10
    } watch_state_t;
endpackage

// File: src/clock_loss_watch.sv
// Purpose: flags a foreign clock that has stopped toggling
// Assumes: watched clock slower than half of mclk_i
// Notes: input passes two flip-flops before any logic reads it
`timescale 1ns/100ps
`include "alarm_regs_consts.svh"
module clock_loss_watch #(
    parameter int LIMIT = `CLK_LOSS_CYCLES
) (
    input wire logic mclk_i,   // system clock
    input wire logic rstn_i,   // sync reset, active low
    input wire logic ce_i,     // clock enable
    input wire logic wclk_i,   // watched clock, asynchronous
    output logic lost_o        // one-cycle pulse when clock stops
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [7:0] cnt;
        alarm_regs_pkg::watch_state_t st;
        logic lost;
    } wstate_t;
    wstate_t q, d;

    always_comb begin
        d = q;
        d.lost = 1'b0;
        d.s1 = wclk_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 != q.s3) begin
            d.cnt = 8'h00;
            d.st = alarm_regs_pkg::WATCH_IDLE;
        end else if (q.cnt < 8'(LIMIT)) begin
            d.cnt = q.cnt + 8'h01;
        end
        case (q.st)
            alarm_regs_pkg::WATCH_IDLE: begin
                if (q.cnt == 8'(LIMIT) && q.s2 == q.s3) begin
                    d.st = alarm_regs_pkg::WATCH_LOST;
                    d.lost = 1'b1;
                end
            end
            alarm_regs_pkg::WATCH_LOST: begin
            end
            default: d.st = alarm_regs_pkg::WATCH_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            q <= '{1'b0, 1'b0, 1'b0, 8'h00, alarm_regs_pkg::WATCH_IDLE, 1'b0};
        end else if (ce_i) begin
            q <= d;
        end
    end
    assign lost_o = q.lost;
endmodule

// File: src/pattern_compare.sv
// Purpose: compares both input buses to the expected pattern per bit
// Assumes: buses sampled on mclk_i, same domain
// Notes: fail bits are per position, ORed across both buses
`timescale 1ns/100ps
module pattern_compare #(
    parameter int W = 16
) (
    input wire logic mclk_i,             // system clock
    input wire logic rstn_i,             // sync reset, active low
    input wire logic ce_i,               // clock enable
    input wire logic en_i,               // checker running
    input wire logic [W-1:0] bus_a_i,    // first input bus
    input wire logic [W-1:0] bus_b_i,    // second input bus
    input wire logic [W-1:0] expect_i,   // expected pattern
    output logic [W-1:0] fail_o          // per-bit mismatch, registered
);
    typedef struct packed {
        logic [W-1:0] fail;
    } pstate_t;
    pstate_t q, d;

    always_comb begin
        d = q;
        d.fail = '0;
        for (int i = 0; i < W; i++) begin
            d.fail[i] = en_i &
                ((bus_a_i[i] ^ expect_i[i]) | (bus_b_i[i] ^ expect_i[i]));
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end
    assign fail_o = q.fail;
endmodule

// File: testbench/clock_source_model.sv
// Purpose: far-side clock sources watched by the alarm register bank
// Assumes: each clock stays slower than half of the system clock
// Notes: a stopped clock stands low, as a halted source would
`timescale 1ns/100ps
module clock_source_model (
    input wire logic conv_run_i, // conversion clock allowed to run
    input wire logic data_run_i, // data clock allowed to run
    output logic conv_clk_o,     // conversion clock
    output logic data_clk_o      // data clock
);
    logic ph = 1'b0;
    // 83 ns half period keeps the phase unrelated to the system clock
    always #83 ph = ~ph;
    assign conv_clk_o = ph & conv_run_i;
    assign data_clk_o = ph & data_run_i;
endmodule

// File: testbench/dac_alarm_status_control_tb.sv
// Purpose: self-checking bench for the alarm register bank
// Assumes: watched clocks come from clock_source_model
// Notes: read results are checked by a monitor against a queue
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("BAD %s exp %h got %h", nm, e, g); \
    end \
end
module dac_alarm_status_control_tb;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic pin_i = 1'b0;
    logic ce = 1'b1;
    logic conv_run = 1'b1;
    logic data_run = 1'b1;
    logic conv_clk;
    logic data_clk;
    logic [7:0] wr_ptr_i = 8'h01;
    logic [2:0] near_i = 3'h0;
    logic [15:0] bus_a = 16'h0000;
    logic [15:0] bus_b = 16'h0000;
    logic [63:0] smp_i = 64'h0;
    logic [63:0] smp_o;
    logic [15:0] rdata_o;
    logic [3:0] fs_o;
    logic tx_o;
    logic shut_o;
    logic irq_o;
    logic [15:0] exp_q[$];
    logic [15:0] e_mon;
    logic rd_seen = 1'b0;
    int n_errors = 0;
    int samples_checked = 0;
    logic [15:0] e;
    logic [15:0] m1;
    logic [15:0] m2;
    logic [3:0] fs;
    logic [15:0] prox[3] = '{16'h0800, 16'h1000, 16'h2100};

    always #20 mclk_i = ~mclk_i;

    clock_source_model src (
        .conv_run_i(conv_run),
        .data_run_i(data_run),
        .conv_clk_o(conv_clk),
        .data_clk_o(data_clk)
    );

    dac_alarm_status_control dut (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .ce_i(ce),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .transmit_enable_pin_i(pin_i),
        .conv_clk_i(conv_clk),
        .data_clk_i(data_clk),
        .wr_ptr_i(wr_ptr_i),
        .fifo_near_i(near_i),
        .first_input_bus_i(bus_a),
        .second_input_bus_i(bus_b),
        .samples_i(smp_i),
        .samples_o(smp_o),
        .full_scale_o(fs_o),
        .tx_enable_o(tx_o),
        .shutdown_o(shut_o),
        .irq_o(irq_o)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    // expected read data is queued here and judged by the monitor
    task automatic rd(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(d);
        @(posedge mclk_i);
        rd_i <= 1'b0;
    endtask

    // second write catches a bit re-set from a sibling alarm in the clear
    task automatic clr(input logic [7:0] a);
        wr(a, 16'hFFFF);
        wr(a, 16'hFFFF);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge mclk_i) begin
        if (rd_seen) begin
            e_mon = exp_q.pop_front();
            `CHK("rdata", e_mon, rdata_o)
        end
        rd_seen <= rd_i;
    end

    initial begin
        tick(4000);
        n_errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h9D0B));
        e = 16'($urandom);
        bus_a <= e;
        bus_b <= e;
        smp_i <= {$urandom, $urandom};
        tick(8);
        rstn_i <= 1'b1;
        rd(8'h03, 16'hF000);
        rd(8'h07, 16'hFFFF);
        rd(8'h05, 16'h0000);
        rd(8'h09, 16'h0007);
        wr(8'h01, 16'hFFFF);
        rd(8'h01, 16'h0000);
        @(negedge mclk_i);
        `CHK("full_scale", 4'hF, fs_o)
        for (int i = 0; i < 4; i++) begin
            fs = 4'($urandom);
            @(posedge mclk_i);
            pin_i <= i[1];
            wr(8'h03, {fs, 11'h000, i[0]});
            tick(3);
            @(negedge mclk_i);
            `CHK("tx_enable", i[0] | i[1], tx_o)
            `CHK("full_scale", fs, fs_o)
            rd(8'h03, {fs, 11'h000, i[0]});
        end
        m1 = 16'($urandom) | 16'h0001;
        m2 = 16'($urandom);
        wr(8'h0B, e);
        wr(8'h0A, 16'h0001);
        clr(8'h04);
        rd(8'h04, 16'h0000);
        bus_a <= e ^ m1;
        bus_b <= e ^ m2;
        @(posedge mclk_i);
        bus_a <= e;
        bus_b <= e;
        tick(3);
        rd(8'h04, m1 | m2);
        rd(8'h05, 16'h0080);
        rd(8'h08, 16'h0004);
        @(negedge mclk_i);
        `CHK("irq", 1'b0, irq_o)
        wr(8'h09, 16'h0000);
        @(negedge mclk_i);
        `CHK("irq", 1'b1, irq_o)
        wr(8'h0A, 16'h0000);
        clr(8'h04);
        clr(8'h05);
        clr(8'h08);
        rd(8'h04, 16'h0000);
        @(negedge mclk_i);
        `CHK("irq", 1'b0, irq_o)
        @(posedge mclk_i);
        wr_ptr_i <= 8'h00;
        @(posedge mclk_i);
        wr_ptr_i <= 8'h01;
        tick(3);
        rd(8'h05, 16'h8000);
        clr(8'h05);
        rd(8'h05, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            near_i <= 3'(1 << i);
            @(posedge mclk_i);
            near_i <= 3'h0;
            tick(3);
            rd(8'h05, prox[i]);
            if (i == 2) begin
                @(negedge mclk_i);
                `CHK("samples", {4{16'h8000}}, smp_o)
                `CHK("shutdown", 1'b0, shut_o)
            end
            clr(8'h05);
            tick(2);
            @(negedge mclk_i);
            `CHK("samples", smp_i, smp_o)
        end
        for (int i = 0; i < 2; i++) begin
            conv_run <= (i != 0);
            data_run <= (i != 1);
            tick(40);
            rd(8'h05, i == 0 ? 16'h0500 : 16'h0300);
            @(negedge mclk_i);
            `CHK("samples", {4{16'h8000}}, smp_o)
            conv_run <= 1'b1;
            data_run <= 1'b1;
            tick(10);
            clr(8'h05);
            rd(8'h05, 16'h0000);
        end
        wr(8'h07, 16'h0000);
        near_i <= 3'h4;
        @(posedge mclk_i);
        near_i <= 3'h0;
        tick(3);
        @(negedge mclk_i);
        `CHK("shutdown", 1'b1, shut_o)
        clr(8'h05);
        @(negedge mclk_i);
        `CHK("shutdown", 1'b0, shut_o)
        rd(8'h07, 16'h0000);
        // a write while the clock enable is low must leave the control word
        ce <= 1'b0;
        wr(8'h03, 16'h0000);
        ce <= 1'b1;
        rd(8'h03, {fs, 11'h000, 1'b1});
        tick(4);
        print_verdict();
    end
endmodule
